// >>> core/mtc_defines.svh
// register map, field positions and timing figures of the tx control block
//
// Operation
// RULE1: three-bit code picks bank, msb set none
// RULE2: bank register upper byte reads 33h
// RULE3: bank register reachable in every bank, not powered down
// RULE4: missing bank drops writes, reads 33h
// RULE5: omit_fcs set drops appended crc
// RULE6: switched mode forces duplex on, monitor off
// RULE7: type low: dma past pointer forces underrun
// RULE8: type high: same packet, send past load
// RULE9: serial loopback before encoder, host resets after
// RULE10: half duplex rejects frames from own source
// RULE11: monitor carrier by preamble end or abort
// RULE12: pad short frames to 64 bytes
// RULE13: force_collision skips deferral, self clears
// RULE14: local loopback after encoder, ignores collision, carrier; code still sets the deferred flag from carrier in local loopback
// RULE15: disable waits frame end; errors clear enable
// RULE16: status word copied out at frame end
// RULE17: underrun sets flag, clears enable; enable clears
// RULE18: rollover set at 15, counter read clears
// RULE19: excessive and deferred flags, cleared per packet
// RULE20: late collision jams; sixteen collisions stop transmit
// RULE21: collision flags and success flag handling
// RULE22: sqe window after frame, error may stop
// RULE23: broadcast, multicast flags follow each frame
`ifndef MTC_DEFINES_SVH
`define MTC_DEFINES_SVH
// word offsets inside the 8-location window
`define MTC_OFS_TCTL      3'h0
`define MTC_OFS_PHYST     3'h1
`define MTC_OFS_STATS     3'h3
`define MTC_OFS_BANK      3'h7
`define MTC_BANK0         3'h0
`define MTC_ID_BYTE       8'h33
`define MTC_BANK_RST      3'h0
// transmit_control bit positions
`define MTC_TC_EN         0
`define MTC_TC_LOOP       1
`define MTC_TC_FCOL       2
`define MTC_TC_PAD        7
`define MTC_TC_NOFCS      8
`define MTC_TC_MON        10
`define MTC_TC_FDX        11
`define MTC_TC_SQSTOP     12
`define MTC_TC_SLOOP      13
`define MTC_TC_UTYPE      14
`define MTC_TC_SWFD       15
// statistics nibble maximum and collision count maximum
`define MTC_CTR_MAX       4'hF
`define MTC_COL_MAX       5'h10
// timing in ns or in bytes, clock period in ns
`define MTC_CLK_NS        100
`define MTC_BYTE_NS       800
`define MTC_SQE_DLY_NS    800
`define MTC_SQE_WIN_NS    1600
`define MTC_IFG_DEF_NS    6400
`define MTC_LATE_BYTES    64
`define MTC_EXC_BYTES     3036
`endif

// >>> core/mtc_pkg.sv
// types shared by the tx control block
package mtc_pkg;
  // host-facing control fields
  typedef struct packed {
    logic sw_fd;
    logic utype;
    logic sloop;
    logic sq_stop;
    logic fdx;
    logic mon;
    logic nofcs;
    logic pad;
    logic fcol;
    logic loop;
    logic en;
  } mtc_ctrl_t;
  // events from the transmit engine
  typedef struct packed {
    logic start;
    logic dst_bcast;
    logic dst_mcast;
    logic pre_end;
    logic done;
    logic coll;
    logic deferring;
  } mtc_evt_t;
  // effective settings handed to the transmit engine
  typedef struct packed {
    logic tx_en;
    logic fcs_append;
    logic pad_short;
    logic full_duplex;
    logic no_defer;
    logic no_coll_det;
    logic serial_loop;
    logic endec_loop;
    logic to_network;
    logic reject_own;
  } mtc_txo_t;
endpackage : mtc_pkg

// >>> core/mtc_cnt.sv
// saturating up counter used for frame, gap and window timing
`timescale 1ns/1ns
`default_nettype none
module mtc_cnt #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         clr_i,
  input  wire logic         en_i,
  output logic [W-1:0]      cnt_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  // stops at all ones so a long wait never wraps back to small
  always_comb begin
    cnt_nxt = cnt_r;
    if (clr_i) begin
      cnt_nxt = '0;
    end else if (en_i && (cnt_r != '1)) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign cnt_o = cnt_r;
endmodule : mtc_cnt
`default_nettype wire

// >>> core/mtc_top.sv
// transmit control, phy status and bank select of the 10 Mb/s controller
`timescale 1ns/1ns
`default_nettype none
`include "mtc_defines.svh"
module mtc_top #(
  parameter int EXCESSIVE_DEFERRAL_FLAG_CYC =
    (`MTC_EXC_BYTES * `MTC_BYTE_NS) / `MTC_CLK_NS
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [2:0]        addr_i,
  input  wire logic [1:0]        be_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [15:0]       wdata_i,
  output logic [15:0]            rdata_o,
  input  wire logic              power_down_i,
  input  wire mtc_pkg::mtc_evt_t evt_i,
  input  wire logic              carrier_pin_i,
  input  wire logic              sqe_pin_i,
  input  wire logic              link_ok_i,
  input  wire logic              wakeup_i,
  input  wire logic              early_tx_enable_i,
  input  wire logic [10:0]       dma_tx_addr_i,
  input  wire logic [10:0]       host_ptr_addr_i,
  input  wire logic [4:0]        load_pkt_i,
  input  wire logic [4:0]        send_pkt_i,
  input  wire logic [10:0]       load_addr_i,
  input  wire logic [10:0]       send_addr_i,
  output mtc_pkg::mtc_txo_t      txo_o,
  output logic                   starve_dma_o,
  output logic                   abort_nofcs_o,
  output logic                   jam_o,
  output logic                   status_wr_o,
  output logic [15:0]            status_word_o
);
  import mtc_pkg::*;

  localparam int SQE_DLY = (`MTC_SQE_DLY_NS + `MTC_CLK_NS - 1) / `MTC_CLK_NS;
  localparam int SQE_WIN = `MTC_SQE_WIN_NS / `MTC_CLK_NS;
  localparam int IFG_DEF = `MTC_IFG_DEF_NS / `MTC_CLK_NS;
  localparam int LATE_CYC = (`MTC_LATE_BYTES * `MTC_BYTE_NS) / `MTC_CLK_NS;

  mtc_ctrl_t   ctl_r, ctl_nxt;
  logic [2:0]  bank_r, bank_nxt;
  logic [15:0] st_r, st_nxt;
  logic [15:0] stats_r, stats_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] snap_r, snap_nxt;
  logic        snap_wr_r, snap_wr_nxt;
  logic [4:0]  ncol_r, ncol_nxt;
  logic        in_frame_r, in_frame_nxt;
  logic        sqe_arm_r, sqe_arm_nxt;
  logic        sqe_seen_r, sqe_seen_nxt;
  logic [2:0]  crs_s, sqe_s;
  logic        crs_q, sqe_q, crs_d;
  logic [15:0] late_cnt, gap_cnt, sqe_cnt;
  logic [31:0] def_cnt;
  logic        bank_ok, bank0, bsr_acc, wr_bank, wr_tc, rd_stats;
  logic        fd_eff, mon_eff, en_set, underrun, lost, late, max_col;
  logic        sqe_fail, sqe_end, deferred, excessive_deferral_flag, fatal, rollover;

  // pins pass three flops; a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      crs_s <= 3'h0;
      sqe_s <= 3'h0;
      crs_q <= 1'b0;
      sqe_q <= 1'b0;
      crs_d <= 1'b0;
    end else begin
      crs_s <= {crs_s[1:0], carrier_pin_i};
      sqe_s <= {sqe_s[1:0], sqe_pin_i};
      if (crs_s[1] == crs_s[2]) crs_q <= crs_s[2];
      if (sqe_s[1] == sqe_s[2]) sqe_q <= sqe_s[2];
      crs_d <= crs_q;
    end
  end

  // bank decode and access qualifiers
  assign bank_ok = !bank_r[2];                           // [RULE1]
  assign bank0   = (bank_r == `MTC_BANK0);
  assign bsr_acc = (addr_i == `MTC_OFS_BANK) && !power_down_i; // [RULE3]
  assign wr_bank = wr_i && bsr_acc && be_i[0];
  assign wr_tc   = wr_i && bank0 && (addr_i == `MTC_OFS_TCTL); // [RULE4]
  assign rd_stats = rd_i && bank0 && (addr_i == `MTC_OFS_STATS);
  assign en_set  = wr_tc && be_i[0] && wdata_i[`MTC_TC_EN];

  // switched mode overrides duplex and carrier monitoring
  assign fd_eff  = ctl_r.fdx || ctl_r.sw_fd;             // [RULE6]
  assign mon_eff = ctl_r.mon && !ctl_r.sw_fd && !ctl_r.loop; // [RULE6] [RULE14]

  // early transmit: starve dma before it reads unloaded data
  always_comb begin
    underrun = 1'b0;
    if (early_tx_enable_i) begin
      if (!ctl_r.utype) begin
        underrun = dma_tx_addr_i > host_ptr_addr_i;       // [RULE7]
      end else begin
        underrun = (load_pkt_i == send_pkt_i) &&
                   (send_addr_i > load_addr_i);           // [RULE8]
      end
    end
  end
  assign starve_dma_o = underrun;                        // [RULE7] [RULE8]

  // frame timing counters
  mtc_cnt #(.W(16)) u_late (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (evt_i.start),
    .en_i    (in_frame_r),
    .cnt_o   (late_cnt)
  );
  mtc_cnt #(.W(16)) u_gap (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (crs_d && !crs_q),
    .en_i    (!crs_q),
    .cnt_o   (gap_cnt)
  );
  mtc_cnt #(.W(16)) u_sqe (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (evt_i.done),
    .en_i    (sqe_arm_r),
    .cnt_o   (sqe_cnt)
  );
  mtc_cnt #(.W(32)) u_def (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (!evt_i.deferring),
    .en_i    (1'b1),
    .cnt_o   (def_cnt)
  );

  // error and event detection; local loopback ignores collision and carrier, but the deferred flag still follows carrier
  assign lost = mon_eff && in_frame_r &&
                ((evt_i.pre_end && !crs_q) ||
                 (crs_d && !crs_q));                     // [RULE11]
  assign late = evt_i.coll && !ctl_r.loop && !ctl_r.sw_fd &&
                (int'(late_cnt) >= LATE_CYC);            // [RULE20]
  assign max_col = evt_i.coll && !ctl_r.loop &&
                   (ncol_r == `MTC_COL_MAX - 5'h1);      // [RULE20]
  assign sqe_end = sqe_arm_r && (int'(sqe_cnt) == SQE_DLY + SQE_WIN - 1);
  assign sqe_fail = sqe_end && !sqe_seen_r && !sqe_q;    // [RULE22]
  assign deferred = evt_i.deferring && crs_q && !crs_d &&
                    (int'(gap_cnt) < IFG_DEF);           // [RULE19]
  assign excessive_deferral_flag = evt_i.deferring && (def_cnt >= 32'(EXCESSIVE_DEFERRAL_FLAG_CYC)); // [RULE19]
  assign fatal = st_r[15] || st_r[4] || st_r[9] || underrun ||
                 (st_r[10] && mon_eff) || (st_r[5] && ctl_r.sq_stop);
  assign abort_nofcs_o = lost;                           // [RULE11]
  assign jam_o = late;                                   // [RULE20]

  // control register: host writes, hardware clears on errors
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_tc && be_i[0]) begin
      ctl_nxt.en   = wdata_i[`MTC_TC_EN];
      ctl_nxt.loop = wdata_i[`MTC_TC_LOOP];
      ctl_nxt.fcol = wdata_i[`MTC_TC_FCOL];
      ctl_nxt.pad  = wdata_i[`MTC_TC_PAD];
    end
    if (wr_tc && be_i[1]) begin
      ctl_nxt.nofcs   = wdata_i[`MTC_TC_NOFCS];
      ctl_nxt.mon     = wdata_i[`MTC_TC_MON];
      ctl_nxt.fdx     = wdata_i[`MTC_TC_FDX];
      ctl_nxt.sq_stop = wdata_i[`MTC_TC_SQSTOP];
      ctl_nxt.sloop   = wdata_i[`MTC_TC_SLOOP];
      ctl_nxt.utype   = wdata_i[`MTC_TC_UTYPE];
      ctl_nxt.sw_fd   = wdata_i[`MTC_TC_SWFD];
    end
    if (evt_i.coll) ctl_nxt.fcol = 1'b0;                 // [RULE13]
    // errors win over a host write in the same cycle
    if (underrun || lost || late || max_col ||
        (sqe_fail && ctl_r.sq_stop)) begin
      ctl_nxt.en = 1'b0;                         // [RULE15] [RULE17] [RULE22]
    end
  end

  // bank code is only three bits; upper byte is a constant
  always_comb begin
    bank_nxt = bank_r;
    if (wr_bank) bank_nxt = wdata_i[2:0];                // [RULE1] [RULE3]
  end

  // frame tracking, collision count and sqe window state
  always_comb begin
    in_frame_nxt = in_frame_r;
    ncol_nxt     = ncol_r;
    sqe_arm_nxt  = sqe_arm_r;
    sqe_seen_nxt = sqe_seen_r;
    if (evt_i.start) begin
      in_frame_nxt = 1'b1;
    end else if (evt_i.done || lost) begin
      in_frame_nxt = 1'b0;
    end
    if (evt_i.coll && ncol_r != `MTC_COL_MAX) ncol_nxt = ncol_r + 5'h1;
    if (evt_i.done) ncol_nxt = 5'h0;
    // no sqe test in switched mode or either loopback
    if (evt_i.done && !ctl_r.sw_fd && !ctl_r.loop && !ctl_r.sloop) begin
      sqe_arm_nxt  = 1'b1;                               // [RULE22]
      sqe_seen_nxt = 1'b0;
    end else if (sqe_end) begin
      sqe_arm_nxt = 1'b0;
    end
    if (sqe_arm_r && int'(sqe_cnt) >= SQE_DLY && sqe_q) sqe_seen_nxt = 1'b1;
  end

  // status flags: a set in the same cycle as a clear wins
  always_comb begin
    st_nxt = st_r;
    st_nxt[14] = link_ok_i;
    st_nxt[13] = 1'b0;
    st_nxt[8]  = wakeup_i;
    if (en_set) begin
      st_nxt[15] = 1'b0; // [RULE17]
      st_nxt[10] = 1'b0;
      st_nxt[9]  = 1'b0; // [RULE20]
      st_nxt[5]  = 1'b0;
      st_nxt[4]  = 1'b0; // [RULE20]
      st_nxt[0]  = 1'b0; // [RULE21]
    end
    if (evt_i.start) begin
      st_nxt[0] = 1'b0; // [RULE21]
      st_nxt[6] = evt_i.dst_bcast; // [RULE23]
      st_nxt[3] = evt_i.dst_mcast && !evt_i.dst_bcast; // [RULE23]
    end
    if (evt_i.done) begin
      st_nxt[11] = 1'b0; // [RULE19]
      st_nxt[7]  = 1'b0; // [RULE19]
      st_nxt[0]  = !fatal; // [RULE21]
      if (!fatal) st_nxt[2:1] = 2'h0; // [RULE21]
    end
    if (rd_stats) st_nxt[12] = 1'b0; // [RULE18]
    if (rollover) st_nxt[12] = 1'b1; // [RULE18]
    if (underrun) st_nxt[15] = 1'b1; // [RULE17]
    if (lost) st_nxt[10] = 1'b1; // [RULE11]
    if (late) st_nxt[9] = 1'b1; // [RULE20]
    if (max_col) st_nxt[4] = 1'b1; // [RULE20]
    if (sqe_fail) st_nxt[5] = 1'b1; // [RULE22]
    if (excessive_deferral_flag) st_nxt[11] = 1'b1; // [RULE19]
    if (deferred) st_nxt[7] = 1'b1; // [RULE19]
    if (evt_i.coll && !ctl_r.loop) begin
      st_nxt[1] = 1'b1;                                  // [RULE21]
      if (ncol_r != 5'h0) st_nxt[2] = 1'b1;              // [RULE21]
    end
  end

  // per-packet statistics nibbles, saturating, cleared by a read
  always_comb begin
    stats_nxt = stats_r;
    rollover  = 1'b0;
    if (rd_stats) stats_nxt = 16'h0000;
    if (evt_i.done) begin
      for (int i = 0; i < 4; i++) begin
        logic hit;
        hit = 1'b0;
        case (i)
          0: hit = st_r[1] && !st_r[2];
          1: hit = st_r[2];
          2: hit = st_r[7];
          default: hit = st_r[11];
        endcase
        if (hit && stats_r[i*4 +: 4] != `MTC_CTR_MAX) begin
          stats_nxt[i*4 +: 4] = stats_nxt[i*4 +: 4] + 4'h1;
          if (stats_r[i*4 +: 4] == `MTC_CTR_MAX - 4'h1) begin
            rollover = 1'b1;                             // [RULE18]
          end
        end
      end
    end
  end

  // copy of the status word handed to buffer memory after each frame
  always_comb begin
    snap_nxt    = snap_r;
    snap_wr_nxt = 1'b0;
    if (evt_i.done) begin
      snap_nxt    = {st_r[15:1], !fatal};                // [RULE16]
      snap_wr_nxt = 1'b1;
    end
  end

  // read data: one cycle after the read strobe
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_i) begin
      if (bsr_acc) begin
        rdata_nxt = {`MTC_ID_BYTE, 5'h00, bank_r};       // [RULE2] [RULE3]
      end else if (!bank_ok) begin
        rdata_nxt = {`MTC_ID_BYTE, `MTC_ID_BYTE};        // [RULE4]
      end else if (bank0 && addr_i == `MTC_OFS_TCTL) begin
        rdata_nxt = {ctl_r.sw_fd, ctl_r.utype, ctl_r.sloop, ctl_r.sq_stop,
                     ctl_r.fdx, ctl_r.mon, 1'b0, ctl_r.nofcs, ctl_r.pad,
                     4'h0, ctl_r.fcol, ctl_r.loop, ctl_r.en};
      end else if (bank0 && addr_i == `MTC_OFS_PHYST) begin
        rdata_nxt = st_r;
      end else if (bank0 && addr_i == `MTC_OFS_STATS) begin
        rdata_nxt = stats_r;
      end else begin
        rdata_nxt = 16'h0000;
      end
    end
  end

  // all state of this block except the pin synchronizers and the timing counters registers here
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctl_r      <= '0;
      bank_r     <= `MTC_BANK_RST;
      st_r       <= 16'h0000;
      stats_r    <= 16'h0000;
      rdata_r    <= 16'h0000;
      snap_r     <= 16'h0000;
      snap_wr_r  <= 1'b0;
      ncol_r     <= 5'h00;
      in_frame_r <= 1'b0;
      sqe_arm_r  <= 1'b0;
      sqe_seen_r <= 1'b0;
    end else begin
      ctl_r      <= ctl_nxt;
      bank_r     <= bank_nxt;
      st_r       <= st_nxt;
      stats_r    <= stats_nxt;
      rdata_r    <= rdata_nxt;
      snap_r     <= snap_nxt;
      snap_wr_r  <= snap_wr_nxt;
      ncol_r     <= ncol_nxt;
      in_frame_r <= in_frame_nxt;
      sqe_arm_r  <= sqe_arm_nxt;
      sqe_seen_r <= sqe_seen_nxt;
    end
  end

  // settings to the transmit engine; the engine finishes a frame on disable
  always_comb begin
    txo_o.tx_en       = ctl_r.en;                        // [RULE15]
    txo_o.fcs_append  = !ctl_r.nofcs;                    // [RULE5]
    txo_o.pad_short   = ctl_r.pad;                       // [RULE12]
    txo_o.full_duplex = fd_eff;                          // [RULE6]
    txo_o.no_defer    = ctl_r.sw_fd || ctl_r.fcol;       // [RULE6] [RULE13]
    txo_o.no_coll_det = ctl_r.sw_fd || ctl_r.loop;       // [RULE6] [RULE14]
    txo_o.serial_loop = ctl_r.sloop;                     // [RULE9]
    txo_o.endec_loop  = ctl_r.loop && !ctl_r.sloop;      // [RULE14]
    txo_o.to_network  = !ctl_r.loop && !ctl_r.sloop;     // [RULE9] [RULE14]
    txo_o.reject_own  = !fd_eff;                         // [RULE10]
  end

  assign rdata_o       = rdata_r;
  assign status_wr_o   = snap_wr_r;
  assign status_word_o = snap_r;
endmodule : mtc_top
`default_nettype wire

// >>> verif/mtc_top_monitor.sv
// port-level assertion checker for the tx control block, with its bind
`timescale 1ns/1ns
`default_nettype none
module mtc_top_chk #(
  parameter int EXCESSIVE_DEFERRAL_FLAG_CYC = 50
) (
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic [2:0]        addr_i,
  input wire logic [1:0]        be_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [15:0]       wdata_i,
  input wire logic [15:0]       rdata_o,
  input wire logic              power_down_i,
  input wire mtc_pkg::mtc_evt_t evt_i,
  input wire logic              early_tx_enable_i,
  input wire mtc_pkg::mtc_txo_t txo_o,
  input wire logic              starve_dma_o,
  input wire logic              abort_nofcs_o,
  input wire logic              jam_o,
  input wire logic              status_wr_o,
  input wire logic [15:0]       status_word_o
);
  import mtc_pkg::*;
  logic [2:0] bank_r;
  logic [9:0] since_r;
  // bank code mirror and cycles since frame start, saturating
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bank_r  <= 3'h0;
      since_r <= 10'h000;
    end else begin
      if (wr_i && be_i[0] && addr_i == 3'h7 && !power_down_i)
        bank_r <= wdata_i[2:0];
      if (evt_i.start)
        since_r <= 10'h000;
      else if (since_r != 10'h3FF)
        since_r <= since_r + 10'h001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_bank_read: assert property (
    rd_i && !wr_i && addr_i == 3'h7 && !power_down_i
    |=> rdata_o == {8'h33, 5'h00, bank_r}) else $error("bank read");
  chk_none_bank: assert property (
    rd_i && bank_r[2] && (addr_i != 3'h7 || power_down_i)
    |=> rdata_o == 16'h3333) else $error("no-bank read");
  chk_empty_bank: assert property (
    rd_i && bank_r inside {3'h1, 3'h2, 3'h3}
    && (addr_i != 3'h7 || power_down_i)
    |=> rdata_o == 16'h0000) else $error("empty bank read");
  chk_dup_reject: assert property (
    txo_o.reject_own == !txo_o.full_duplex) else $error("own reject");
  chk_loop_quiet: assert property (
    txo_o.serial_loop || txo_o.endec_loop |-> !txo_o.to_network)
    else $error("loop reaches network");
  chk_copy_pulse: assert property (
    evt_i.done |=> status_wr_o && status_word_o[13] == 1'b0)
    else $error("status copy missing");
  chk_copy_cause: assert property (
    status_wr_o |-> $past(evt_i.done)) else $error("stray status copy");
  chk_late_jam: assert property (
    jam_o |-> evt_i.coll && since_r > 10'h1FE) else $error("early jam");
  chk_jam_stop: assert property (
    jam_o && !wr_i |=> !txo_o.tx_en) else $error("jam kept enable");
  chk_abort_stop: assert property (
    abort_nofcs_o && !wr_i |=> !txo_o.tx_en) else $error("abort kept enable");
  chk_starve_gate: assert property (
    !early_tx_enable_i |-> !starve_dma_o) else $error("starve without early");
  chk_starve_stop: assert property (
    starve_dma_o && !wr_i |=> !txo_o.tx_en) else $error("underrun kept enable");
endmodule : mtc_top_chk
bind mtc_top mtc_top_chk #(.EXCESSIVE_DEFERRAL_FLAG_CYC(EXCESSIVE_DEFERRAL_FLAG_CYC)) u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .be_i(be_i),
  .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .power_down_i(power_down_i), .evt_i(evt_i),
  .early_tx_enable_i(early_tx_enable_i), .txo_o(txo_o),
  .starve_dma_o(starve_dma_o), .abort_nofcs_o(abort_nofcs_o),
  .jam_o(jam_o), .status_wr_o(status_wr_o), .status_word_o(status_word_o)
);
`default_nettype wire

// >>> verif/mtc_net_model.sv
// network side model: own carrier echo and heartbeat after each frame
`timescale 1ns/1ns
`default_nettype none
module mtc_net_model (
  input  wire logic frame_on_i,
  input  wire logic carrier_ok_i,
  input  wire logic sqe_ok_i,
  input  wire logic slow_i,
  output logic      carrier_pin_o,
  output logic      sqe_pin_o
);
  // carrier echoed only while our frame is on
  assign carrier_pin_o = frame_on_i & carrier_ok_i;
  // heartbeat inside the window, slow one later but still inside it
  initial sqe_pin_o = 1'b0;
  always @(negedge frame_on_i) begin
    if (sqe_ok_i) begin
      #(slow_i ? 1200 : 900);
      sqe_pin_o = 1'b1;
      #400;
      sqe_pin_o = 1'b0;
    end
  end
endmodule : mtc_net_model
`default_nettype wire

// >>> verif/tb_mac_tx_control_status.sv
// self-checking bench for the tx control block
`timescale 1ns/1ns
`default_nettype none
module tb_mac_tx_control_status;
  import mtc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [2:0]  addr_i = 3'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o, sword, v;
  logic        pd = 1'b0, early = 1'b0, dfr = 1'b0;
  mtc_evt_t    evt_i = '0;
  logic [10:0] dma = 11'h000, host = 11'h000, la = 11'h000, sa = 11'h000;
  logic [4:0]  lp = 5'h00, sp = 5'h00;
  mtc_txo_t    txo_o;
  logic        starve, abort, jam, swr, car, sqe, fd;
  logic        fon = 1'b0, car_ok = 1'b1, sqe_ok = 1'b1, slow = 1'b0;
  logic        seen_ab = 1'b0, seen_jam = 1'b0;
  int          error_cnt = 0, compares = 0, seed = 32'h415A;
  int          ctl_m, st_m, bank_m;
  always #50 clk_i = ~clk_i;
  // pulses too short to poll are latched here
  always @(posedge clk_i) begin
    if (abort) seen_ab <= 1'b1;
    if (jam) seen_jam <= 1'b1;
  end
  mtc_top #(.EXCESSIVE_DEFERRAL_FLAG_CYC(50)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .be_i(2'h3),
    .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .power_down_i(pd), .evt_i(evt_i), .carrier_pin_i(car),
    .sqe_pin_i(sqe), .link_ok_i(1'b1), .wakeup_i(1'b0),
    .early_tx_enable_i(early), .dma_tx_addr_i(dma), .host_ptr_addr_i(host),
    .load_pkt_i(lp), .send_pkt_i(sp), .load_addr_i(la), .send_addr_i(sa),
    .txo_o(txo_o), .starve_dma_o(starve), .abort_nofcs_o(abort),
    .jam_o(jam), .status_wr_o(swr), .status_word_o(sword));
  mtc_net_model u_net (.frame_on_i(fon), .carrier_ok_i(car_ok),
    .sqe_ok_i(sqe_ok), .slow_i(slow), .carrier_pin_o(car), .sqe_pin_o(sqe));
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] g, e, m);
    compares++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g & m, e & m);
    end
  endtask : chk
  task automatic reset_dut();
    @(posedge clk_i);
    #2 rst_b_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #2 rst_b_i = 1'b1;
    ctl_m = 0;
    st_m = 32'h4000;
    bank_m = 0;
  endtask : reset_dut
  // write; model tracks bank and control
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #2 addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(posedge clk_i);
    #2 wr_i = 1'b0;
    if (!pd && a == 3'h7) bank_m = d[2:0];
    else if (bank_m == 0 && a == 3'h0) begin
      if (d[0]) st_m &= ~32'h8631;
      ctl_m = d & 16'hFD87;
    end
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] e, m);
    @(posedge clk_i);
    #2 addr_i = a;
    rd_i = 1'b1;
    @(posedge clk_i);
    #2 rd_i = 1'b0;
    chk(rdata_o, e, m);
  endtask : rd
  // one-cycle engine event, deferring level kept as set
  task automatic ev(input logic [6:0] e);
    @(posedge clk_i);
    #2 evt_i = mtc_evt_t'(e | {6'h00, dfr});
    @(posedge clk_i);
    #2 evt_i = mtc_evt_t'({6'h00, dfr});
  endtask : ev
  // early-transmit inputs, starve checked at once
  task automatic ur(input logic e, input logic [10:0] d, h,
                    input logic [4:0] l, s, input logic [10:0] a, x);
    @(posedge clk_i);
    #2 {early, dma, host, lp, sp, la, sa} = {e, d, h, l, s, 11'h00A, a};
    #3 chk({15'h0, starve}, {15'h0, x[0]}, 16'h0001);
    if (x[0]) {st_m[15], ctl_m[0]} = 2'b10;
  endtask : ur
  // start, preamble end, collisions, done, sqe
  task automatic frame(input int ncol, input logic [1:0] d, input int gap);
    logic fatal;
    ev({1'b1, d, 4'h0});
    st_m = (st_m & ~32'h0049) | {d[1], 2'b00, d[0], 3'b000};
    fon = 1'b1;
    repeat (gap) @(posedge clk_i);
    ev(7'h08);
    if (ctl_m[10] && !car_ok) st_m |= 32'h0400;
    for (int i = 0; i < ncol; i++) ev(7'h02);
    if (ncol > 0) st_m |= (ncol > 1) ? 32'h6 : 32'h2;
    if (ncol >= 16) st_m |= 32'h10;
    if (ncol > 0 && gap >= 512) st_m |= 32'h200;
    if (ncol > 0) ctl_m &= ~32'h4;
    fatal = (st_m & 32'h8610) != 0;
    if (fatal) ctl_m &= ~32'h1;
    ev(7'h04);
    chk({15'h0, swr}, 16'h0001, 16'h0001);
    chk(sword, st_m | {15'h0, !fatal}, 16'h065F);
    fon = 1'b0;
    if (!fatal) st_m = (st_m & ~32'h6) | 32'h1;
    repeat (30) @(posedge clk_i);
    if (!sqe_ok) st_m |= 32'h20;
    if (!sqe_ok && ctl_m[12]) ctl_m &= ~32'h1;
    rd(3'h1, st_m, 16'hC67F);
    rd(3'h0, ctl_m, 16'hFD87);
  endtask : frame
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end
  initial begin
    reset_dut();
    rd(3'h0, 16'h0000, 16'hFFFF);
    rd(3'h1, 16'h4000, 16'hFFFF);
    chk({6'h00, txo_o}, 16'h0103, 16'h03FF);
    // every bank code, with a control write that only bank 0 takes
    for (int b = 0; b < 8; b++) begin
      wr(3'h7, 16'(b));
      wr(3'h0, 16'h0180);
      rd(3'h7, 16'h3300 | 16'(b), 16'hFFFF);
      rd(3'h0, b > 3 ? 16'h3333 : (b == 0 ? 16'(ctl_m) : 16'h0000),
         16'hFFFF);
    end
    wr(3'h7, 16'h0000);
    pd = 1'b1;
    wr(3'h7, 16'h0004);
    rd(3'h7, 16'h0000, 16'hFFFF);
    pd = 1'b0;
    rd(3'h7, 16'h3300, 16'hFFFF);
    // random options against engine settings
    for (int i = 0; i < 8; i++) begin
      v = 16'($random(seed)) & 16'hFD82;
      wr(3'h0, v);
      fd = v[11] | v[15];
      chk(16'(txo_o), {7'h00, !v[8], v[7], fd, v[15], v[15] | v[1], v[13],
          v[1] & !v[13], !(v[13] | v[1]), !fd},
          16'h03FF);
      rd(3'h0, v, 16'hFD87);
    end
    reset_dut();
    wr(3'h0, 16'h0001);
    frame(0, 2'b10, 6);
    slow = 1'b1;
    frame(2, 2'b01, 6);
    slow = 1'b0;
    wr(3'h0, 16'h1001);
    sqe_ok = 1'b0;
    frame(0, 2'b00, 6);
    sqe_ok = 1'b1;
    wr(3'h0, 16'h0401);
    car_ok = 1'b0;
    frame(0, 2'b00, 6);
    car_ok = 1'b1;
    chk({15'h0, seen_ab}, 16'h0001, 16'h0001);
    wr(3'h0, 16'h0001);
    frame(1, 2'b00, 520);
    chk({15'h0, seen_jam}, 16'h0001, 16'h0001);
    wr(3'h0, 16'h0001);
    frame(16, 2'b00, 6);
    wr(3'h0, 16'h0005);
    frame(1, 2'b00, 6);
    rd(3'h3, 16'h0031, 16'hFFFF);
    for (int i = 0; i < 15; i++) frame(1, 2'b00, 6);
    rd(3'h1, 16'h1000, 16'h1000);
    rd(3'h3, 16'h000F, 16'hFFFF);
    rd(3'h1, 16'h0000, 16'h1000);
    dfr = 1'b1;
    ev(7'h00);
    repeat (60) @(posedge clk_i);
    rd(3'h1, 16'h0800, 16'h0800);
    dfr = 1'b0;
    frame(0, 2'b00, 6);
    rd(3'h1, 16'h0000, 16'h0880);
    // underrun, both comparison types
    ur(1'b1, 11'd40, 11'd50, 5'd0, 5'd0, 11'd0, 1'b0);
    ur(1'b1, 11'd100, 11'd50, 5'd0, 5'd0, 11'd0, 1'b1);
    ur(1'b0, 11'd100, 11'd50, 5'd0, 5'd0, 11'd0, 1'b0);
    rd(3'h1, st_m, 16'hC67F);
    rd(3'h0, ctl_m, 16'hFD87);
    wr(3'h0, 16'h4001);
    ur(1'b1, 11'd10, 11'd50, 5'd3, 5'd4, 11'd20, 1'b0);
    ur(1'b1, 11'd10, 11'd50, 5'd3, 5'd3, 11'd20, 1'b1);
    ur(1'b0, 11'd10, 11'd50, 5'd3, 5'd3, 11'd20, 1'b0);
    rd(3'h1, st_m, 16'hC67F);
    wr(3'h0, 16'h0001);
    rd(3'h1, st_m, 16'hC67F);
    end_of_test();
  end
endmodule : tb_mac_tx_control_status
`default_nettype wire
